/* File: verilog/cfglk_regs.sv */
// configuration lock, revision, smi routing and battery-backed pin select
// assumes reg port on ref_clk; pins and battery reset are asynchronous
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
module cfglk_regs
  import cfglk_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic nrst_battery,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic access_lock_input_n,
  input wire logic lock_pin_selected,
  input wire logic [4:0] func_activate,
  input wire logic global_enable,
  input wire logic [5:0] smi_sources,
  input wire logic supply_control_straps,
  output logic [4:0] func_active,
  output logic system_mgmt_interrupt,
  output logic [7:0] pin_select,
  output logic irq
);
  import cfglk_pkg::*;

  logic [7:0] disable_reg;
  logic [7:0] smi_reg;
  logic [7:0] pinsel_reg;
  logic [5:0] stat_reg;
  logic [5:0] mask_reg;
  logic [5:0] src_s1_reg;
  logic [5:0] src_reg;
  logic [5:0] src_prev_reg;
  logic lock_s1_reg;
  logic lock_reg;
  logic strap_s1_reg;
  logic strap_reg;
  logic strap_done_reg;
  logic batt_up_s1_reg;
  logic batt_up_reg;
  logic hw_lock;
  logic sw_locked;
  logic dis_wr_ok;
  logic [5:0] rise;
  logic [7:0] rd_next;

  // lock and smi source pins cross in through two flops before use
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lock_s1_reg <= 1'b0;
      lock_reg <= 1'b0;
      src_s1_reg <= 6'h00;
      src_reg <= 6'h00;
      src_prev_reg <= 6'h00;
    end
    else
    begin
      lock_s1_reg <= ~access_lock_input_n;
      lock_reg <= lock_s1_reg;
      src_s1_reg <= smi_sources;
      src_reg <= src_s1_reg;
      src_prev_reg <= src_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst_battery)
  begin
    if (!nrst_battery)
    begin
      strap_s1_reg <= 1'b0;
      strap_reg <= 1'b0;
      batt_up_s1_reg <= 1'b0;
      batt_up_reg <= 1'b0;
    end
    else
    begin
      strap_s1_reg <= supply_control_straps;
      strap_reg <= strap_s1_reg;
      // marks the edge where strap_reg first holds a real pin sample, not its reset value
      batt_up_s1_reg <= 1'b1;
      batt_up_reg <= batt_up_s1_reg;
    end
  end

  assign hw_lock = lock_reg & lock_pin_selected;
  assign sw_locked = disable_reg[BIT_SW_LOCK];
  assign dis_wr_ok = sw_locked ? 1'b0 : ~hw_lock;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      disable_reg <= RESET_VALUE;
    end
    else if (reg_wr && reg_addr == OFS_DISABLE && !hw_lock)
    begin
      // lock bit only ever ORs in; clearing needs reset
      disable_reg[BIT_SW_LOCK] <= sw_locked | reg_wdata[BIT_SW_LOCK];
      if (dis_wr_ok)
      begin
        disable_reg[6:0] <= reg_wdata[6:0] & DISABLE_WMASK[6:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      smi_reg <= RESET_VALUE;
    end
    else if (reg_wr && reg_addr == OFS_SMI)
    begin
      smi_reg <= reg_wdata & SMI_WMASK;
    end
  end

  // battery domain: survives the main reset
  always_ff @(posedge ref_clk or negedge nrst_battery)
  begin
    if (!nrst_battery)
    begin
      pinsel_reg <= RESET_VALUE;
      strap_done_reg <= 1'b0;
    end
    else
    begin
      if (batt_up_reg && !strap_done_reg)
      begin
        pinsel_reg[BIT_PIN_STRAP] <= strap_reg;
        strap_done_reg <= 1'b1;
      end
      if (reg_wr && reg_addr == OFS_PINSEL)
      begin
        // bit 0 fixed low, bit 7 read-only
        pinsel_reg[6:0] <= reg_wdata[6:0] & PINSEL_WMASK[6:0];
      end
    end
  end

  generate
    genvar gi;
    for (gi = 0; gi < NUM_FUNC; gi++)
    begin : g_func
      always_ff @(posedge ref_clk or negedge nrst)
      begin
        if (!nrst)
          func_active[gi] <= 1'b0;
        else
          func_active[gi] <= ~disable_reg[gi] & func_activate[gi] & global_enable;
      end
    end
  endgenerate

  assign rise = src_reg & ~src_prev_reg;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      system_mgmt_interrupt <= 1'b0;
    else
      system_mgmt_interrupt <= |(src_reg & smi_reg[5:0]);
  end

  // new edges win over the clear-on-read
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      stat_reg <= 6'h00;
    else if (reg_rd && reg_addr == OFS_IRQ_STATUS)
      stat_reg <= rise;
    else
      stat_reg <= stat_reg | rise;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      mask_reg <= 6'h00;
    else if (reg_wr && reg_addr == OFS_IRQ_MASK)
      mask_reg <= reg_wdata[5:0];
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= |(stat_reg & mask_reg);
  end

  always_ff @(posedge ref_clk or negedge nrst_battery)
  begin
    if (!nrst_battery)
      pin_select <= RESET_VALUE;
    else
      pin_select <= pinsel_reg;
  end

  always_comb
  begin
    rd_next = 8'h00;
    case (reg_addr)
      OFS_DISABLE: rd_next = disable_reg;
      OFS_REVISION: rd_next = REVISION_CODE;
      OFS_SMI: rd_next = smi_reg;
      OFS_PINSEL: rd_next = pinsel_reg;
      OFS_IRQ_STATUS: rd_next = {2'b00, stat_reg};
      OFS_IRQ_MASK: rd_next = {2'b00, mask_reg};
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_next;
    else
      reg_rdata <= 8'h00;
  end

  property p_swlock_sticks;
    @(posedge ref_clk) disable iff (!nrst) disable_reg[7] |=> disable_reg[7];
  endproperty
  a_swlock_sticks: assert property (p_swlock_sticks) else $error("software lock cleared");

  property p_locked_ro;
    @(posedge ref_clk) disable iff (!nrst) disable_reg[7] |=> $stable(disable_reg[6:0]);
  endproperty
  a_locked_ro: assert property (p_locked_ro) else $error("locked bits changed");

  property p_hwlock_blocks;
    @(posedge ref_clk) disable iff (!nrst) hw_lock |=> $stable(disable_reg);
  endproperty
  a_hwlock_blocks: assert property (p_hwlock_blocks) else $error("write passed lock pin");

  property p_unlocked_write;
    @(posedge ref_clk) disable iff (!nrst)
      (reg_wr && reg_addr == OFS_DISABLE && !hw_lock && !disable_reg[7])
      |=> disable_reg[6:0] == $past(reg_wdata[6:0]);
  endproperty
  a_unlocked_write: assert property (p_unlocked_write) else $error("unlocked write lost");

  property p_active;
    @(posedge ref_clk) disable iff (!nrst) func_active[0] |-> $past(func_activate[0] & global_enable & ~disable_reg[0]);
  endproperty
  a_active: assert property (p_active) else $error("function active wrongly");

  property p_rev;
    @(posedge ref_clk) disable iff (!nrst) (reg_rd && reg_addr == OFS_REVISION) |=> reg_rdata == REVISION_CODE;
  endproperty
  a_rev: assert property (p_rev) else $error("bad revision read");

  property p_smi;
    @(posedge ref_clk) disable iff (!nrst) system_mgmt_interrupt |-> $past(|(src_reg & smi_reg[5:0]));
  endproperty
  a_smi: assert property (p_smi) else $error("smi without enabled source");

  property p_pin0;
    @(posedge ref_clk) disable iff (!nrst_battery) !pinsel_reg[0];
  endproperty
  a_pin0: assert property (p_pin0) else $error("pin select bit 0 set");

  // lock and disable checks
  property p_swlock_set;
    @(posedge ref_clk) disable iff (!nrst)
      (reg_wr && reg_addr == OFS_DISABLE && !hw_lock && reg_wdata[BIT_SW_LOCK]) |=> disable_reg[BIT_SW_LOCK];
  endproperty
  a_swlock_set: assert property (p_swlock_set) else $error("software lock not set");

  property p_lock_unselected;
    @(posedge ref_clk) disable iff (!nrst)
      (reg_wr && reg_addr == OFS_DISABLE && !lock_pin_selected && !disable_reg[7]) |=> disable_reg[6:0] == $past(reg_wdata[6:0]);
  endproperty
  a_lock_unselected: assert property (p_lock_unselected) else $error("unselected lock pin blocked write");

  property p_inactive;
    @(posedge ref_clk) disable iff (!nrst) disable_reg[1] |=> !func_active[1];
  endproperty
  a_inactive: assert property (p_inactive) else $error("disabled function active");

  property p_func_on;
    @(posedge ref_clk) disable iff (!nrst) (func_activate[0] && global_enable && !disable_reg[0]) |=> func_active[0];
  endproperty
  a_func_on: assert property (p_func_on) else $error("enabled function not active");

  property p_rdata_disable;
    @(posedge ref_clk) disable iff (!nrst)
      (reg_rd && reg_addr == OFS_DISABLE) |=> reg_rdata == $past(disable_reg);
  endproperty
  a_rdata_disable: assert property (p_rdata_disable) else $error("bad disable read");

  // smi routing checks
  property p_smi_write;
    @(posedge ref_clk) disable iff (!nrst)
      (reg_wr && reg_addr == OFS_SMI) |=> smi_reg == ($past(reg_wdata) & SMI_WMASK);
  endproperty
  a_smi_write: assert property (p_smi_write) else $error("smi enable write lost");

  property p_smi_reserved;
    @(posedge ref_clk) disable iff (!nrst) smi_reg[7:6] == 2'b00;
  endproperty
  a_smi_reserved: assert property (p_smi_reserved) else $error("smi reserved bits set");

  property p_smi_route;
    @(posedge ref_clk) disable iff (!nrst) |(src_reg & smi_reg[5:0]) |=> system_mgmt_interrupt;
  endproperty
  a_smi_route: assert property (p_smi_route) else $error("enabled source not routed");

  property p_smi_off;
    @(posedge ref_clk) disable iff (!nrst) !(|(src_reg & smi_reg[5:0])) |=> !system_mgmt_interrupt;
  endproperty
  a_smi_off: assert property (p_smi_off) else $error("smi without source");

  property p_rdata_smi;
    @(posedge ref_clk) disable iff (!nrst)
      (reg_rd && reg_addr == OFS_SMI) |=> reg_rdata == $past(smi_reg);
  endproperty
  a_rdata_smi: assert property (p_rdata_smi) else $error("bad smi enable read");

  // battery-domain checks
  property p_strap_ro;
    @(posedge ref_clk) disable iff (!nrst_battery) strap_done_reg |=> $stable(pinsel_reg[BIT_PIN_STRAP]);
  endproperty
  a_strap_ro: assert property (p_strap_ro) else $error("strap bit changed");

  property p_pin6;
    @(posedge ref_clk) disable iff (!nrst_battery)
      (reg_wr && reg_addr == OFS_PINSEL) |=> pinsel_reg[6] == $past(reg_wdata[6]);
  endproperty
  a_pin6: assert property (p_pin6) else $error("chassis select write lost");

  property p_pin54;
    @(posedge ref_clk) disable iff (!nrst_battery)
      (reg_wr && reg_addr == OFS_PINSEL) |=> pinsel_reg[5:4] == $past(reg_wdata[5:4]);
  endproperty
  a_pin54: assert property (p_pin54) else $error("ring select write lost");

  property p_pin3;
    @(posedge ref_clk) disable iff (!nrst_battery)
      (reg_wr && reg_addr == OFS_PINSEL) |=> pinsel_reg[3] == $past(reg_wdata[3]);
  endproperty
  a_pin3: assert property (p_pin3) else $error("second led select write lost");

  property p_pin21;
    @(posedge ref_clk) disable iff (!nrst_battery)
      (reg_wr && reg_addr == OFS_PINSEL) |=> pinsel_reg[2:1] == $past(reg_wdata[2:1]);
  endproperty
  a_pin21: assert property (p_pin21) else $error("first led select write lost");

  property p_pin_out;
    @(posedge ref_clk) disable iff (!nrst_battery) pin_select == $past(pinsel_reg);
  endproperty
  a_pin_out: assert property (p_pin_out) else $error("pin select output stale");

  property p_pin_keep;
    @(posedge ref_clk) disable iff (!nrst_battery)
      (!nrst && !reg_wr && strap_done_reg) |=> $stable(pinsel_reg);
  endproperty
  a_pin_keep: assert property (p_pin_keep) else $error("pin select lost in main reset");

  property p_rdata_pinsel;
    @(posedge ref_clk) disable iff (!nrst)
      (reg_rd && reg_addr == OFS_PINSEL) |=> !reg_rdata[0];
  endproperty
  a_rdata_pinsel: assert property (p_rdata_pinsel) else $error("pin select bit 0 read set");

  c_sw_lock: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(disable_reg[7]));
  c_hw_block: cover property (@(posedge ref_clk) disable iff (!nrst) hw_lock && reg_wr && reg_addr == OFS_DISABLE);
  c_smi: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(system_mgmt_interrupt));
  c_pin_write: cover property (@(posedge ref_clk) disable iff (!nrst_battery) reg_wr && reg_addr == OFS_PINSEL);
  c_irq: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(irq));
endmodule // cfglk_regs

/* File: verilog/cfglk_pkg.sv */
// constants for the configuration lock, smi routing and pin select bank
// assumes a plain index/strobe register port on the host clock
package cfglk_pkg;
  localparam logic [7:0] OFS_DISABLE = 8'h26;
  localparam logic [7:0] OFS_REVISION = 8'h27;
  localparam logic [7:0] OFS_SMI = 8'h28;
  localparam logic [7:0] OFS_PINSEL = 8'h2a;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h2e;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2f;
  localparam int BIT_SW_LOCK = 7;
  localparam logic [7:0] DISABLE_WMASK = 8'h7f;
  localparam logic [7:0] SMI_WMASK = 8'h3f;
  localparam logic [7:0] PINSEL_WMASK = 8'h7e;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] REVISION_CODE = 8'h01; // arbitrary value
  localparam int NUM_FUNC = 5;
  localparam int NUM_SMI = 6;
  localparam int BIT_PIN_STRAP = 7;
endpackage

/* File: verification/cfglk_regs_tb.sv */
// self-checking bench for the config lock, smi routing and pin select bank
// assumes the one-cycle strobe register port; the bench drives every pin
`timescale 1ns/100ps
module config_lock_smi_pin_select_regs_tb_top;
  import cfglk_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic nrst_battery = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic access_lock_input_n = 1'b1;
  logic lock_pin_selected = 1'b0;
  logic [4:0] func_activate = 5'h00;
  logic global_enable = 1'b0;
  logic [5:0] smi_sources = 6'h00;
  logic supply_control_straps = 1'b1;
  logic [4:0] func_active;
  logic system_mgmt_interrupt;
  logic [7:0] pin_select;
  logic irq;
  int n_mismatch = 0;
  int checks = 0;

  always #4 ref_clk = ~ref_clk;

  cfglk_regs cfglk_regs_inst (
    .ref_clk(ref_clk), .nrst(nrst), .nrst_battery(nrst_battery),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .access_lock_input_n(access_lock_input_n),
    .lock_pin_selected(lock_pin_selected), .func_activate(func_activate),
    .global_enable(global_enable), .smi_sources(smi_sources),
    .supply_control_straps(supply_control_straps), .func_active(func_active),
    .system_mgmt_interrupt(system_mgmt_interrupt), .pin_select(pin_select), .irq(irq)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t output %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe is taken
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // main reset only; the battery domain must ride through it
  task automatic main_reset();
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
  endtask

  task automatic give_verdict();
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge ref_clk);
    n_mismatch++;
    give_verdict();
  end

  initial
  begin
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    nrst_battery <= 1'b1;
    settle(4);
    rd(OFS_DISABLE, RESET_VALUE);
    rd(OFS_SMI, RESET_VALUE);
    rd(OFS_REVISION, REVISION_CODE);
    rd(OFS_PINSEL, 8'h80);
    chk_out(pin_select, 8'h80);
    rd(8'h29, 8'h00);
    wr(OFS_REVISION, 8'h5a);
    rd(OFS_REVISION, REVISION_CODE);
    wr(OFS_SMI, 8'hff);
    rd(OFS_SMI, 8'h3f);
    wr(OFS_PINSEL, 8'hff);
    rd(OFS_PINSEL, 8'hfe);
    wr(OFS_PINSEL, 8'h12);
    rd(OFS_PINSEL, 8'h92);
    main_reset();
    rd(OFS_PINSEL, 8'h92);
    rd(OFS_SMI, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge ref_clk);
      smi_sources <= 6'h01 << i;
      wr(OFS_SMI, 8'h01 << i);
      settle(4);
      chk_out({7'h00, system_mgmt_interrupt}, 8'h01);
      wr(OFS_SMI, ~(8'h01 << i) & 8'h3f);
      settle(4);
      chk_out({7'h00, system_mgmt_interrupt}, 8'h00);
    end
    chk_out({7'h00, irq}, 8'h00);
    rd(OFS_IRQ_STATUS, 8'h3f);
    settle(2);
    chk_out({7'h00, irq}, 8'h00);
    wr(OFS_IRQ_MASK, 8'h3f);
    smi_sources <= 6'h00;
    settle(3);
    @(posedge ref_clk);
    smi_sources <= 6'h01;
    settle(5);
    chk_out({7'h00, irq}, 8'h01);
    rd(OFS_IRQ_STATUS, 8'h01);
    settle(2);
    chk_out({7'h00, irq}, 8'h00);
    @(posedge ref_clk);
    global_enable <= 1'b1;
    func_activate <= 5'h1f;
    settle(3);
    chk_out({3'h0, func_active}, 8'h1f);
    wr(OFS_DISABLE, 8'h75);
    settle(2);
    chk_out({3'h0, func_active}, 8'h0a);
    rd(OFS_DISABLE, 8'h75);
    @(posedge ref_clk);
    access_lock_input_n <= 1'b0;
    settle(3);
    wr(OFS_DISABLE, 8'h03);
    rd(OFS_DISABLE, 8'h03);
    @(posedge ref_clk);
    lock_pin_selected <= 1'b1;
    settle(3);
    wr(OFS_DISABLE, 8'h80);
    rd(OFS_DISABLE, 8'h03);
    @(posedge ref_clk);
    access_lock_input_n <= 1'b1;
    settle(3);
    wr(OFS_DISABLE, 8'h85);
    rd(OFS_DISABLE, 8'h85);
    wr(OFS_DISABLE, 8'h00);
    rd(OFS_DISABLE, 8'h85);
    wr(OFS_DISABLE, 8'hfa);
    rd(OFS_DISABLE, 8'h85);
    main_reset();
    rd(OFS_DISABLE, 8'h00);
    give_verdict();
  end
endmodule // config_lock_smi_pin_select_regs_tb_top
